// [ebrs_defines.vh]
`ifndef EBRS_DEFINES_VH
`define EBRS_DEFINES_VH

// Bus widths
`define EBRS_AW          12
`define EBRS_DW          16
`define EBRS_PA_MSB      2
`define EBRS_PA_LSB      0

// Reset and constant values
`define EBRS_PC_RST      12'h000
`define EBRS_ADDR_RST    12'h000
`define EBRS_PORT_HI     9'h1ff
`define EBRS_DATA_RST    16'h0000

// Clock division: four master clocks per bus cycle
`define EBRS_DIV         4
`define EBRS_PH_LAST     2'h3
`define EBRS_PH_STB0     2'h0
`define EBRS_PH_STB1     2'h1
`define EBRS_PH_CAPT     2'h2
`define EBRS_SYSTEM_CLOCK_OUT_HI   2'h2
`define EBRS_RST_MIN_CYC 5

// Bus cycle kinds
`define EBRS_SL_IDLE     3'h0
`define EBRS_SL_FETCH    3'h1
`define EBRS_SL_DUMMY    3'h2
`define EBRS_SL_TDATA    3'h3
`define EBRS_SL_TWRITE   3'h4
`define EBRS_SL_PIN      3'h5
`define EBRS_SL_POUT     3'h6
`define EBRS_SL_PWR      3'h7

// Instruction classes presented by the core
`define EBRS_OP_PLAIN    3'h0
`define EBRS_OP_TABLE_READ_INSTR     3'h1
`define EBRS_OP_TABLE_WRITE_INSTR     3'h2
`define EBRS_OP_IN       3'h3
`define EBRS_OP_OUT      3'h4
`define EBRS_OP_PWR      3'h5

`endif

// [ebrs_clk_sync.v]
`timescale 1ns/1ps
`include "ebrs_defines.vh"

module ebrs_clk_sync (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Reset pin
  input  wire       reset_in_n,
  // Derived timing
  output wire [1:0] phase,
  output wire       system_clock_out,
  output wire       reset_sync_n
);

  reg [1:0] phase_q;
  reg       system_clock_out_q;
  reg       rmeta_q;
  reg       rsync_q;

  always @(posedge clk) begin
    if (srst) begin
      phase_q  <= 2'h0;
      system_clock_out_q <= 1'b1;
      rmeta_q  <= 1'b0;
      rsync_q  <= 1'b0;
    end else begin
      phase_q  <= phase_q + 2'h1;
      system_clock_out_q <= ((phase_q + 2'h1) < `EBRS_SYSTEM_CLOCK_OUT_HI);
      // Entry and exit land on the second edge after the pin change
      rmeta_q  <= reset_in_n;
      rsync_q  <= rmeta_q;
    end
  end

  assign phase            = phase_q;
  assign system_clock_out = system_clock_out_q;
  assign reset_sync_n     = rsync_q;

endmodule

// [ebrs_bus_ctrl.v]
// Operation
// - Reset low holds port, write and memory strobes high.
// - Reset low releases all sixteen data lines.
// - One full cycle after reset falls, address and program counter clear.
// - Execution resumes one complete cycle after reset rises.
// - Reset input passes a clock synchronizer; entry and exit delays vary.
// - At most one of the three strobes is asserted at once.
// - Twelve-bit program address output, most to least significant.
// - Address outputs always driven, floated only during reset.
// - Port transfers put a three-bit port address on low lines.
// - Port transfers drive the upper nine address lines high.
// - Data bus released except while write strobe is low.
// - Data bus also driven while an internal peripheral is written.
// - Source select 0 fetches internally, 1 fetches externally.
// - Code protect blocks every external path into internal program memory.
// - Table read: prefetch, dummy prefetch, data fetch, next prefetch.
// - Table write: prefetch, dummy prefetch, write cycle, next prefetch.
// - System clock output is master clock divided by four.
`timescale 1ns/1ps
`include "ebrs_defines.vh"

module ebrs_bus_ctrl (
  // Master clock and reset
  input  wire        clk,
  input  wire        srst,
  // Pins: reset, mode straps
  input  wire        reset_in_n,
  input  wire        program_source_select,
  input  wire        code_protect_bit,
  // Pins: clock out
  output wire        system_clock_out,
  // Pins: address bus
  output wire [11:0] address_outputs,
  output wire        address_oe,
  // Pins: strobes
  output wire        port_strobe_n,
  output wire        memory_strobe_n,
  output wire        write_strobe_n,
  // Pins: data bus
  input  wire [15:0] data_in,
  output wire [15:0] data_out,
  output wire        data_oe,
  // Internal program memory
  output wire [11:0] irom_addr,
  output wire        irom_rd,
  input  wire [15:0] irom_data,
  // Core instruction port
  input  wire        op_valid,
  input  wire [2:0]  op_code,
  input  wire [11:0] op_addr,
  input  wire [15:0] op_wdata,
  output wire        op_ready,
  // Core results
  output wire        instr_valid,
  output wire [15:0] instr_data,
  output wire        rd_valid,
  output wire [15:0] rd_data,
  output wire [11:0] pc_out,
  output wire        core_reset
);

  // Strobe vector {port, write, memory}, active high inside
  function [2:0] slot_strobes;
    input [2:0] slot;
    input       ext;
    begin
      case (slot)
        `EBRS_SL_FETCH:  slot_strobes = {2'b00, ext};
        `EBRS_SL_DUMMY:  slot_strobes = {2'b00, ext};
        `EBRS_SL_TDATA:  slot_strobes = {2'b00, ext};
        `EBRS_SL_TWRITE: slot_strobes = 3'b010;
        `EBRS_SL_PIN:    slot_strobes = 3'b100;
        `EBRS_SL_POUT:   slot_strobes = 3'b010;
        default:         slot_strobes = 3'b000;
      endcase
    end
  endfunction

  wire [1:0] phase;
  wire       rsync_n;

  ebrs_clk_sync u_sync (
    .clk              (clk),
    .srst             (srst),
    .reset_in_n       (reset_in_n),
    .phase            (phase),
    .system_clock_out (system_clock_out),
    .reset_sync_n     (rsync_n)
  );

  reg [2:0]  slot_q;
  reg [2:0]  slot_d;
  reg [2:0]  opc_q;
  reg [11:0] tbl_addr_q;
  reg [15:0] wdata_q;
  reg [11:0] pc_q;
  reg [11:0] addr_q;
  reg [11:0] addr_d;
  reg        addr_oe_q;
  reg [2:0]  stb_q;
  reg        doe_q;
  reg [15:0] dout_q;
  reg        ext_q;
  reg        rst_seen_q;
  reg        wake_q;
  reg        run_q;
  reg        ivld_q;
  reg [15:0] idata_q;
  reg        rvld_q;
  reg [15:0] rdata_q;

  wire       boundary = (phase == `EBRS_PH_LAST);
  wire       stb_win  = (phase == `EBRS_PH_STB0) || (phase == `EBRS_PH_STB1);
  wire       capture  = (phase == `EBRS_PH_CAPT);
  wire [2:0] stb_now  = slot_strobes(slot_q, ext_q);
  // Internal memory is unreachable while code runs from outside and protect is set
  wire       irom_ok  = ~(ext_q && code_protect_bit);
  wire       int_src  = ~ext_q && irom_ok;
  wire       rd_int   = (slot_q == `EBRS_SL_TDATA) && int_src;
  wire       fe_int   = (slot_q == `EBRS_SL_FETCH) && ~ext_q;

  // Slot sequencing at the end of each bus cycle
  always @* begin
    slot_d = `EBRS_SL_FETCH;
    case (slot_q)
      `EBRS_SL_IDLE: begin
        slot_d = run_q ? `EBRS_SL_FETCH : `EBRS_SL_IDLE;
      end
      `EBRS_SL_FETCH: begin
        case (opc_q)
          `EBRS_OP_TABLE_READ_INSTR: slot_d = `EBRS_SL_DUMMY;
          `EBRS_OP_TABLE_WRITE_INSTR: slot_d = `EBRS_SL_DUMMY;
          `EBRS_OP_IN:   slot_d = `EBRS_SL_PIN;
          `EBRS_OP_OUT:  slot_d = `EBRS_SL_POUT;
          `EBRS_OP_PWR:  slot_d = `EBRS_SL_PWR;
          default:       slot_d = `EBRS_SL_FETCH;
        endcase
      end
      `EBRS_SL_DUMMY: begin
        if (opc_q == `EBRS_OP_TABLE_READ_INSTR)
          slot_d = `EBRS_SL_TDATA;
        else
          slot_d = `EBRS_SL_TWRITE;
      end
      default: begin
        slot_d = `EBRS_SL_FETCH;
      end
    endcase
  end

  // Address for the coming slot
  always @* begin
    addr_d = pc_q;
    case (slot_d)
      `EBRS_SL_FETCH:  addr_d = pc_q;
      `EBRS_SL_DUMMY:  addr_d = pc_q;
      `EBRS_SL_TDATA:  addr_d = tbl_addr_q;
      `EBRS_SL_TWRITE: addr_d = tbl_addr_q;
      `EBRS_SL_PIN:    addr_d = {`EBRS_PORT_HI, tbl_addr_q[`EBRS_PA_MSB:`EBRS_PA_LSB]};
      `EBRS_SL_POUT:   addr_d = {`EBRS_PORT_HI, tbl_addr_q[`EBRS_PA_MSB:`EBRS_PA_LSB]};
      default:         addr_d = addr_q;
    endcase
  end

  // New instruction is taken when its prefetch cycle starts
  assign op_ready = run_q && rsync_n && boundary && (slot_d == `EBRS_SL_FETCH);

  // Reset entry, clear and resume
  always @(posedge clk) begin
    if (srst) begin
      rst_seen_q <= 1'b0;
      wake_q     <= 1'b0;
      run_q      <= 1'b0;
      ext_q      <= 1'b0;
    end else begin
      // Source select is only looked at while the core is held; code protect is used at all times
      if (!rsync_n)
        ext_q <= program_source_select;
      if (!rsync_n) begin
        run_q  <= 1'b0;
        wake_q <= 1'b0;
        if (boundary)
          rst_seen_q <= 1'b1;
      end else if (boundary) begin
        if (!run_q && !wake_q) begin
          wake_q <= 1'b1;
        end else if (wake_q) begin
          wake_q     <= 1'b0;
          run_q      <= 1'b1;
          rst_seen_q <= 1'b0;
        end
      end
    end
  end

  // Slot, program counter and address
  always @(posedge clk) begin
    if (srst) begin
      slot_q     <= `EBRS_SL_IDLE;
      opc_q      <= `EBRS_OP_PLAIN;
      tbl_addr_q <= `EBRS_ADDR_RST;
      wdata_q    <= `EBRS_DATA_RST;
      pc_q       <= `EBRS_PC_RST;
      addr_q     <= `EBRS_ADDR_RST;
      addr_oe_q  <= 1'b0;
    end else if (!rsync_n) begin
      slot_q    <= `EBRS_SL_IDLE;
      opc_q     <= `EBRS_OP_PLAIN;
      addr_oe_q <= 1'b0;
      // A cycle already seen in reset means a full cycle has passed
      if (boundary && rst_seen_q) begin
        pc_q   <= `EBRS_PC_RST;
        addr_q <= `EBRS_ADDR_RST;
      end
    end else if (boundary) begin
      slot_q    <= slot_d;
      addr_q    <= addr_d;
      addr_oe_q <= 1'b1;
      if (slot_d == `EBRS_SL_FETCH) begin
        pc_q <= pc_q + 12'h001;
        if (op_ready && op_valid) begin
          opc_q      <= op_code;
          tbl_addr_q <= op_addr;
          wdata_q    <= op_wdata;
        end else begin
          opc_q <= `EBRS_OP_PLAIN;
        end
      end
    end
  end

  // Strobes and data drive
  always @(posedge clk) begin
    if (srst) begin
      stb_q  <= 3'b000;
      doe_q  <= 1'b0;
      dout_q <= `EBRS_DATA_RST;
    end else if (!rsync_n) begin
      stb_q <= 3'b000;
      doe_q <= 1'b0;
    end else begin
      // Strobes sit inside the cycle so the address is stable around them
      stb_q  <= (stb_win && run_q) ? stb_now : 3'b000;
      doe_q  <= stb_win && run_q && (stb_now[1] || (slot_q == `EBRS_SL_PWR));
      if (boundary)
        dout_q <= wdata_q;
    end
  end

  // Read capture at the last strobe phase
  always @(posedge clk) begin
    if (srst) begin
      ivld_q  <= 1'b0;
      idata_q <= `EBRS_DATA_RST;
      rvld_q  <= 1'b0;
      rdata_q <= `EBRS_DATA_RST;
    end else begin
      ivld_q <= 1'b0;
      rvld_q <= 1'b0;
      if (capture && run_q && rsync_n) begin
        if (slot_q == `EBRS_SL_FETCH) begin
          ivld_q  <= 1'b1;
          idata_q <= fe_int ? irom_data : data_in;
        end
        if (slot_q == `EBRS_SL_TDATA || slot_q == `EBRS_SL_PIN) begin
          rvld_q  <= 1'b1;
          rdata_q <= rd_int ? irom_data : data_in;
        end
      end
    end
  end

  assign address_outputs = addr_q;
  assign address_oe      = addr_oe_q;
  assign port_strobe_n   = ~stb_q[2];
  assign write_strobe_n  = ~stb_q[1];
  assign memory_strobe_n = ~stb_q[0];
  assign data_out        = dout_q;
  assign data_oe         = doe_q;
  assign irom_addr       = irom_ok ? addr_q : `EBRS_ADDR_RST;
  assign irom_rd         = fe_int || rd_int;
  assign instr_valid     = ivld_q;
  assign instr_data      = idata_q;
  assign rd_valid        = rvld_q;
  assign rd_data         = rdata_q;
  assign pc_out          = pc_q;
  assign core_reset      = ~run_q;

endmodule

// [ebrs_monitor.sv]
`timescale 1ns/1ps
module ebrs_monitor (
  // Clock and reset
  input wire        clk,
  input wire        srst,
  input wire        reset_in_n,
  // Bus pins
  input wire        system_clock_out,
  input wire [11:0] address_outputs,
  input wire        address_oe,
  input wire        port_strobe_n,
  input wire        memory_strobe_n,
  input wire        write_strobe_n,
  input wire        data_oe
);
  wire any_stb;
  assign any_stb = !(port_strobe_n && memory_strobe_n && write_strobe_n);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Long enough for two sync flops plus two bus-cycle boundaries
  sequence rst_held;
    !reset_in_n [*8] ##1 !reset_in_n [*8];
  endsequence
  sequence mem_pulse;
    ##1 !memory_strobe_n ##1 memory_strobe_n;
  endsequence
  sequence clk_wave;
    ##1 system_clock_out ##1 !system_clock_out [*2] ##1 system_clock_out;
  endsequence
  AST_ONE_STROBE: assert property ($onehot0({!port_strobe_n, !memory_strobe_n, !write_strobe_n}))
    else $error("two strobes low together");
  AST_RST_STROBES: assert property (!reset_in_n [*4] |-> any_stb == 1'b0)
    else $error("strobe low in reset");
  AST_RST_DATA: assert property (!reset_in_n [*4] |-> !data_oe)
    else $error("data driven in reset");
  AST_RST_ADDR: assert property (rst_held |-> address_outputs == 12'h000)
    else $error("address not cleared in reset");
  AST_WR_DATA: assert property (!write_strobe_n |-> data_oe)
    else $error("write strobe without data drive");
  AST_RD_FLOAT: assert property (data_oe |-> port_strobe_n || !write_strobe_n)
    else $error("data driven during read");
  AST_PORT_HIGH: assert property (!port_strobe_n |-> address_outputs[11:3] == 9'h1ff)
    else $error("port upper address not high");
  AST_ADDR_HOLD: assert property (any_stb && $past(any_stb) |-> $stable(address_outputs))
    else $error("address moved under strobe");
  AST_MEM_LEN: assert property ($fell(memory_strobe_n) |-> mem_pulse)
    else $error("memory strobe length wrong");
  AST_CLK_DIV: assert property ($rose(system_clock_out) |-> clk_wave)
    else $error("clock out not divided by four");
  AST_ADDR_FLOAT: assert property ($fell(address_oe) |-> !reset_in_n)
    else $error("address floated outside reset");
endmodule

bind ebrs_bus_ctrl ebrs_monitor mon_u (
  .clk              (clk),
  .srst             (srst),
  .reset_in_n       (reset_in_n),
  .system_clock_out (system_clock_out),
  .address_outputs  (address_outputs),
  .address_oe       (address_oe),
  .port_strobe_n    (port_strobe_n),
  .memory_strobe_n  (memory_strobe_n),
  .write_strobe_n   (write_strobe_n),
  .data_oe          (data_oe)
);

// [ebrs_ext_mem.sv]
`timescale 1ns/1ps
module ebrs_ext_mem (
  // Clock
  input  wire        clk,
  // Bus from device
  input  wire [11:0] address_outputs,
  input  wire        memory_strobe_n,
  input  wire        port_strobe_n,
  // Read data
  output reg  [15:0] data_in
);
  initial data_in = 16'h0000;
  // Released bus toggles so a stale word never reads as valid
  // No write storage: a write cut by reset never counts as landed
  always @(posedge clk) begin
    if (!memory_strobe_n)
      data_in <= {4'h5, address_outputs};
    else if (!port_strobe_n)
      data_in <= {4'h9, address_outputs};
    else
      data_in <= ~data_in;
  end
endmodule

// [external_bus_reset_sequencing_bench.sv]
`timescale 1ns/1ps
module external_bus_reset_sequencing_bench;
  reg         clk;
  reg         srst;
  reg         reset_in_n;
  reg         op_valid;
  reg  [2:0]  op_code;
  reg  [11:0] op_addr;
  reg  [15:0] op_wdata;
  reg         program_source_select;
  reg         code_protect_bit;
  wire [11:0] irom_addr;
  wire [15:0] irom_data;
  wire        irom_rd;
  wire        instr_valid;
  wire [15:0] instr_data;
  wire [11:0] pc_out;
  wire        core_reset;
  integer     men_cnt;
  wire [11:0] address_outputs;
  wire [15:0] data_in;
  wire [15:0] data_out;
  wire [15:0] rd_data;
  wire        port_strobe_n;
  wire        memory_strobe_n;
  wire        write_strobe_n;
  wire        data_oe;
  wire        address_oe;
  wire        op_ready;
  wire        rd_valid;
  wire [6:0]  ev;
  integer     num_errors;
  integer     checked;
  integer     n;

  assign ev = {instr_valid, data_oe, !port_strobe_n, !write_strobe_n, !memory_strobe_n,
               rd_valid, op_ready};

  // Internal memory model: each word carries its own address
  assign irom_data = {4'ha, irom_addr};

  // Counts clocks with the memory strobe low, cleared by the internal-mode test
  always @(negedge clk) begin
    if (memory_strobe_n === 1'b0)
      men_cnt = men_cnt + 1;
  end

  ebrs_bus_ctrl dut_u (
    .clk(clk), .srst(srst), .reset_in_n(reset_in_n),
    .program_source_select(program_source_select), .code_protect_bit(code_protect_bit),
    .system_clock_out(), .address_outputs(address_outputs), .address_oe(address_oe),
    .port_strobe_n(port_strobe_n), .memory_strobe_n(memory_strobe_n),
    .write_strobe_n(write_strobe_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .irom_addr(irom_addr), .irom_rd(irom_rd), .irom_data(irom_data),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_wdata(op_wdata),
    .op_ready(op_ready), .instr_valid(instr_valid), .instr_data(instr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .pc_out(pc_out), .core_reset(core_reset)
  );

  ebrs_ext_mem mem_u (
    .clk(clk), .address_outputs(address_outputs), .memory_strobe_n(memory_strobe_n),
    .port_strobe_n(port_strobe_n), .data_in(data_in)
  );

  task stop_test;
    begin
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task chk(input [127:0] what, input [15:0] exp, input [15:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", what, exp, got);
      end
    end
  endtask

  task wait_for(input integer k);
    begin
      n = 0;
      while (n < 64 && ev[k] !== 1'b1) begin
        @(negedge clk);
        n = n + 1;
      end
      if (ev[k] !== 1'b1) begin
        chk("wait", 16'h0001, 16'h0000);
        stop_test;
      end
    end
  endtask

  task issue(input [2:0] c, input [11:0] a, input [15:0] w);
    begin
      @(posedge clk);
      #10;
      op_valid = 1'b1;
      op_code = c;
      op_addr = a;
      op_wdata = w;
      wait_for(0);
      @(posedge clk);
      #10;
      op_valid = 1'b0;
    end
  endtask

  task t_reset;
    begin
      @(posedge clk);
      #10;
      reset_in_n = 1'b0;
      repeat (24) @(posedge clk);
      #10;
      chk("strobes", 16'h0007, {13'h0, port_strobe_n, memory_strobe_n, write_strobe_n});
      chk("data_oe", 16'h0000, {15'h0, data_oe});
      chk("addr", 16'h0000, {4'h0, address_outputs});
      chk("core_rst", 16'h0001, {15'h0, core_reset});
      reset_in_n = 1'b1;
      wait_for(2);
      chk("fetch", 16'h0000, {4'h0, address_outputs});
      chk("addr_oe", 16'h0001, {15'h0, address_oe});
      chk("pc", 16'h0001, {4'h0, pc_out});
      chk("core_run", 16'h0000, {15'h0, core_reset});
      wait_for(6);
      chk("instr", 16'h5000, instr_data);
      $display("test reset done");
    end
  endtask

  task t_table;
    begin
      issue(3'h1, 12'h0a5, 16'h0000);
      wait_for(1);
      chk("table_read_instr", 16'h50a5, rd_data);
      issue(3'h2, 12'h033, 16'hbeef);
      wait_for(3);
      chk("tw_addr", 16'h0033, {4'h0, address_outputs});
      chk("tw_data", 16'hbeef, data_out);
      $display("test table done");
    end
  endtask

  task t_port;
    begin
      issue(3'h3, 12'h00d, 16'h0000);
      wait_for(4);
      chk("pin_addr", 16'h0ffd, {4'h0, address_outputs});
      wait_for(1);
      chk("pin_data", 16'h9ffd, rd_data);
      issue(3'h4, 12'h002, 16'h1234);
      wait_for(3);
      chk("pout_addr", 16'h0ffa, {4'h0, address_outputs});
      chk("pout_data", 16'h1234, data_out);
      issue(3'h5, 12'h000, 16'h00aa);
      wait_for(5);
      chk("pwr_data", 16'h00aa, data_out);
      $display("test port done");
    end
  endtask

  task t_midrst;
    begin
      @(posedge clk);
      #10;
      code_protect_bit = 1'b1;
      wait_for(0);
      chk("irom_addr", 16'h0000, {4'h0, irom_addr});
      // Entry on a boundary edge so no fetch strobe is cut short
      t_reset;
      $display("test midrst done");
    end
  endtask

  task t_intern;
    begin
      @(posedge clk);
      #10;
      program_source_select = 1'b0;
      code_protect_bit = 1'b0;
      reset_in_n = 1'b0;
      repeat (24) @(posedge clk);
      #10;
      reset_in_n = 1'b1;
      men_cnt = 0;
      wait_for(6);
      chk("int_instr", 16'ha000, instr_data);
      chk("irom_rd", 16'h0001, {15'h0, irom_rd});
      issue(3'h1, 12'h0a5, 16'h0000);
      wait_for(1);
      chk("int_table_read_instr", 16'ha0a5, rd_data);
      chk("int_men", 16'h0000, men_cnt[15:0]);
      $display("test intern done");
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    reset_in_n = 1'b1;
    op_valid = 1'b0;
    op_code = 3'h0;
    op_addr = 12'h000;
    op_wdata = 16'h0000;
    program_source_select = 1'b1;
    code_protect_bit = 1'b0;
    men_cnt = 0;
    num_errors = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    #10;
    srst = 1'b0;
    t_reset;
    t_table;
    t_port;
    t_midrst;
    t_intern;
    stop_test;
  end
endmodule
